// ==== core/ctf_pkg.sv ====
// Package of offsets, fields and constants for the tile and flash register block
package ctf_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [15:0] ADDR_COLOR_TILE = 16'h1040;
  localparam logic [15:0] ADDR_NVM_CTRL = 16'h1240;
  localparam logic [15:0] ADDR_NVM_WINDOW = 16'h1244;
  localparam logic [15:0] ADDR_NVM_DATA = 16'h1248;
  localparam logic [15:0] ADDR_CSR_LOW = 16'h0000;
  localparam logic [15:0] ADDR_CSR_HIGH = 16'h1FFF;
  // ----------------------------------------
  // Colour letters
  // ----------------------------------------
  localparam logic [7:0] LETTER_RED = 8'h52;
  localparam logic [7:0] LETTER_GREEN = 8'h47;
  localparam logic [7:0] LETTER_BLUE = 8'h42;
  localparam logic [7:0] LETTER_MONO = 8'h59;
  // ----------------------------------------
  // Control field positions, bit 31 is the word MSB
  // ----------------------------------------
  localparam int POS_PRESENT = 31;
  localparam int POS_CLEAN = 25;
  localparam int POS_SIZE_LSB = 12;
  localparam int POS_COUNT_LSB = 0;
  localparam logic [11:0] PAGE_SIZE_CODE = 12'h008;
  localparam logic [11:0] PAGE_COUNT_CODE = 12'h00B;
  // ----------------------------------------
  // Page buffer and flash sizing
  // ----------------------------------------
  localparam int PAGE_WORDS = 64;
  localparam int PAGE_AW = 6;
  localparam int FLASH_PAGES = 2048;
  localparam int PAGE_NUM_W = 11;
  localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [31:0] RESET_OFFSET = 32'h00000000;
  localparam logic [5:0] LAST_WORD = 6'h3F;
endpackage

// ==== core/ctf_regs.sv ====
// APB register block for colour tile layout and user flash page access
//
// Behaviour
// (R1) Tile register: four read-only byte fields
// (R2) Fields hold ASCII colour initials
// (R3) Processed output reports YYYY, 0x59595959
// (R4) RGGB reads 0x52474742, pixel (0,0) high
// (R5) Unwritten flash reads back all ones
// (R6) Host streams data, then one commit write
// (R7) Commit on control write or other access
// (R8) Bit 0 flags feature present
// (R9) Bit 6 reads 0 dirty, 1 clean
// (R10) Writing 1 to bit 6 programs page
// (R11) Bits 8-19 give page size exponent
// (R12) Bits 20-31 give page count exponent
// (R13) Window register holds 32-bit data offset
// (R14) Bit 0 is the word's MSB
// (R15) Reserved control bits read zero
`timescale 1ns/100ps
module ctf_regs
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Device status
  input wire logic RAW_MOSAIC,
  input wire logic [31:0] TILE_PATTERN,
  input wire logic NVM_PRESENT,
  output logic NVM_BUSY
);
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_mapped(input logic [15:0] a);
    is_mapped = (a == ctf_pkg::ADDR_COLOR_TILE) || (a == ctf_pkg::ADDR_NVM_CTRL) ||
                (a == ctf_pkg::ADDR_NVM_WINDOW) || (a == ctf_pkg::ADDR_NVM_DATA);
  endfunction

  function automatic logic is_csr(input logic [15:0] a);
    is_csr = (a <= ctf_pkg::ADDR_CSR_HIGH) && (a != ctf_pkg::ADDR_NVM_WINDOW) &&
             (a != ctf_pkg::ADDR_NVM_DATA);
  endfunction

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_PROG = 3'b010,
    ST_DONE = 3'b100
  } ctf_state_t;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [31:0] flash_mem [ctf_pkg::FLASH_PAGES * ctf_pkg::PAGE_WORDS];
  logic [31:0] page_buf [ctf_pkg::PAGE_WORDS];
  logic [31:0] nvm_offset_value;
  logic page_dirty;
  logic [ctf_pkg::PAGE_AW-1:0] prog_idx;
  logic [ctf_pkg::PAGE_NUM_W-1:0] page_num;
  logic [ctf_pkg::PAGE_AW-1:0] word_idx;
  logic [ctf_pkg::PAGE_NUM_W+ctf_pkg::PAGE_AW-1:0] mem_addr;
  logic [ctf_pkg::FLASH_PAGES-1:0] page_valid;
  logic [ctf_pkg::PAGE_WORDS-1:0] buf_written;
  logic [31:0] flash_rd;
  logic [31:0] prog_old;
  ctf_state_t state;
  ctf_state_t next_state;

  logic setup;
  logic access;
  logic wr_access;
  logic commit_req;
  logic busy;

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && PREADY;
  assign wr_access = access && PWRITE;
  assign busy = (state != ST_IDLE);
  assign NVM_BUSY = busy;
  assign page_num = nvm_offset_value[ctf_pkg::PAGE_NUM_W+7:8];
  assign word_idx = nvm_offset_value[7:2];
  assign mem_addr = {page_num, prog_idx};
  // Pages never programmed read as erased ones
  assign flash_rd = page_valid[page_num] ? flash_mem[{page_num, word_idx}] : ctf_pkg::ERASED_WORD;  // see (R5)
  assign prog_old = page_valid[page_num] ? flash_mem[mem_addr] : ctf_pkg::ERASED_WORD;  // see (R5)

  // Commit on clean-bit write, or any access to a CSR other than the control, window and data registers
  always_comb
  begin
    commit_req = 1'b0;
    if (access && page_dirty && NVM_PRESENT)
    begin
      if (PWRITE && PADDR == ctf_pkg::ADDR_NVM_CTRL)
      begin
        commit_req = PWDATA[ctf_pkg::POS_CLEAN];  // see (R10)
      end
      else if (is_csr(PADDR) && PADDR != ctf_pkg::ADDR_NVM_CTRL)
      begin
        commit_req = 1'b1;  // see (R7)
      end
    end
  end

  // ----------------------------------------
  // Program sequencer
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (commit_req)
        begin
          next_state = ST_PROG;  // see (R6)
        end
      end
      ST_PROG:
      begin
        if (prog_idx == ctf_pkg::LAST_WORD)
        begin
          next_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      prog_idx <= '0;
    end
    else if (state == ST_PROG)
    begin
      prog_idx <= prog_idx + 6'h01;
    end
    else
    begin
      prog_idx <= '0;
    end
  end

  // Page programmed flags, all pages erased after reset
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      page_valid <= '0;  // see (R5)
    end
    else if (state == ST_DONE)
    begin
      page_valid[page_num] <= 1'b1;
    end
  end

  // Words of the buffer written since the last commit
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      buf_written <= '0;
    end
    else if (wr_access && PADDR == ctf_pkg::ADDR_NVM_DATA && !busy)
    begin
      buf_written[word_idx] <= 1'b1;
    end
    else if (state == ST_DONE)
    begin
      buf_written <= '0;
    end
  end

  // ----------------------------------------
  // Flash array and page buffer
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (state == ST_PROG)
    begin
      // Untouched words keep their old or erased value
      flash_mem[mem_addr] <= buf_written[prog_idx] ? page_buf[prog_idx] : prog_old;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (wr_access && PADDR == ctf_pkg::ADDR_NVM_DATA && !busy)
    begin
      page_buf[word_idx] <= PWDATA;
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      page_dirty <= 1'b0;
    end
    else if (wr_access && PADDR == ctf_pkg::ADDR_NVM_DATA && !busy)
    begin
      page_dirty <= 1'b1;  // see (R9)
    end
    else if (state == ST_DONE)
    begin
      page_dirty <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      nvm_offset_value <= ctf_pkg::RESET_OFFSET;
    end
    else if (wr_access && PADDR == ctf_pkg::ADDR_NVM_WINDOW && !page_dirty && !busy)
    begin
      nvm_offset_value <= PWDATA;  // see (R13)
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  assign PREADY = !busy || !(PADDR == ctf_pkg::ADDR_NVM_DATA || PADDR == ctf_pkg::ADDR_NVM_WINDOW);
  assign PSLVERR = access && !is_mapped(PADDR);

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PRDATA <= '0;
    end
    else if (setup && !PWRITE)
    begin
      case (PADDR)
        ctf_pkg::ADDR_COLOR_TILE:
        begin
          // Byte for pixel (0,0) in the MSB
          PRDATA <= RAW_MOSAIC ? TILE_PATTERN : {4{ctf_pkg::LETTER_MONO}};  // see (R1) see (R2) see (R3) see (R4)
        end
        ctf_pkg::ADDR_NVM_CTRL:
        begin
          PRDATA <= '0;  // see (R15)
          PRDATA[ctf_pkg::POS_PRESENT] <= NVM_PRESENT;  // see (R8) see (R14)
          PRDATA[ctf_pkg::POS_CLEAN] <= !page_dirty;  // see (R9)
          PRDATA[ctf_pkg::POS_SIZE_LSB +: 12] <= ctf_pkg::PAGE_SIZE_CODE;  // see (R11)
          PRDATA[ctf_pkg::POS_COUNT_LSB +: 12] <= ctf_pkg::PAGE_COUNT_CODE;  // see (R12)
        end
        ctf_pkg::ADDR_NVM_WINDOW:
        begin
          PRDATA <= nvm_offset_value;
        end
        ctf_pkg::ADDR_NVM_DATA:
        begin
          PRDATA <= buf_written[word_idx] ? page_buf[word_idx] : flash_rd;  // see (R5)
        end
        default:
        begin
          PRDATA <= '0;
        end
      endcase
    end
  end
endmodule

// ==== sim/ctf_regs_props.sv ====
// Port checker of the tile and flash register block
`timescale 1ns/100ps
module ctf_props
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Device status
  input wire logic RAW_MOSAIC,
  input wire logic [31:0] TILE_PATTERN,
  input wire logic NVM_PRESENT,
  input wire logic NVM_BUSY
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  sequence rd_setup(a, c);
    PSEL && !PENABLE && !PWRITE && PADDR == a && c;
  endsequence
  chk_tile_mono:
    assert property (rd_setup(16'h1040, !RAW_MOSAIC) |=> PRDATA == 32'h59595959) else $error("tile not mono");
  chk_tile_raw:
    assert property (rd_setup(16'h1040, RAW_MOSAIC) |=> PRDATA == $past(TILE_PATTERN)) else $error("tile wrong");
  chk_ctrl_codes:
    assert property (rd_setup(16'h1240, 1'b1) |=> PRDATA[23:0] == 24'h00800B) else $error("codes wrong");
  chk_ctrl_resv:
    assert property (rd_setup(16'h1240, 1'b1) |=> PRDATA[30:26] == 5'h00 && !PRDATA[24]) else $error("resv set");
  chk_present_bit:
    assert property (rd_setup(16'h1240, 1'b1) |=> PRDATA[31] == $past(NVM_PRESENT)) else $error("present");
  chk_busy_stall:
    assert property (NVM_BUSY && PSEL && PENABLE && PADDR == 16'h1244 |-> !PREADY) else $error("no stall");
  chk_unmapped_err:
    assert property (PSEL && PENABLE && PADDR > 16'h1FFF |-> PSLVERR && PREADY) else $error("no error");
  chk_tile_nowait:
    assert property (PSEL && PENABLE && PADDR == 16'h1040 |-> PREADY && !PSLVERR) else $error("tile wait");
endmodule

// ==== sim/test_camera_tile_and_flash_csrs.sv ====
// Self-checking bench of the tile and flash register block
`timescale 1ns/100ps
module test_camera_tile_and_flash_csrs;
  logic CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, RAW_MOSAIC = 1, NVM_PRESENT = 1;
  logic PREADY, PSLVERR, NVM_BUSY, er;
  logic [15:0] PADDR = 0;
  logic [31:0] PWDATA = 0, TILE_PATTERN = 0, PRDATA, rd, sd = 32'hB382D14F, off;
  int errors = 0, compares = 0, k;
  ctf_regs ctf_regs_i (.*);
  initial
  begin
    forever #10 CLK = ~CLK;
  end
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t %h %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 200);
    rd = PRDATA;
    er = PSLVERR;
    if (n >= 200)
    begin
      errors++;
      tally_and_finish();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task tally_and_finish;
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (5000) @(posedge CLK);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    for (k = 0; k < 6; k++)
    begin
      sd = xs(sd);
      RAW_MOSAIC <= sd[0] | (k == 0);
      NVM_PRESENT <= sd[1];
      TILE_PATTERN <= (k == 0) ? 32'h52474742 : sd;
      apb(1'b1, 16'h1040, sd);
      apb(1'b0, 16'h1040, 32'h0);
      chk(rd, RAW_MOSAIC ? TILE_PATTERN : 32'h59595959);
      apb(1'b1, 16'h1240, sd & 32'hFDFFFFFF);
      apb(1'b0, 16'h1240, 32'h0);
      chk(rd, {NVM_PRESENT, 7'h02, 24'h00800B});
      apb(1'b0, 16'h2000 | sd[15:0], 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
    end
    NVM_PRESENT <= 1'b1;
    off = {13'h0000, sd[18:2], 2'b00};
    apb(1'b1, 16'h1244, off);
    apb(1'b0, 16'h1244, 32'h0);
    chk(rd, off);
    apb(1'b0, 16'h1248, 32'h0);
    chk(rd, 32'hFFFFFFFF);
    for (k = 0; k < 2; k++)
    begin
      sd = xs(sd);
      apb(1'b1, 16'h1248, sd);
      apb(1'b1, 16'h1240, 32'h0);
      apb(1'b0, 16'h1240, 32'h0);
      chk({31'h0, rd[25]}, 32'h0);
      apb(1'b1, k ? 16'h1040 : 16'h1240, 32'h02000000);
      apb(1'b0, 16'h1248, 32'h0);
      chk(rd, sd);
      apb(1'b0, 16'h1240, 32'h0);
      chk({31'h0, rd[25]}, 32'h1);
    end
    tally_and_finish();
  end
endmodule
bind ctf_regs ctf_props ctf_props_i (.*);
